//--- rtl/pfp_scenario.sv
`timescale 1ns/1ns
module pfp_scenario (
    // values
    input  wire logic [7:0] current,
    input  wire logic [7:0] written,
    // mode
    input  wire logic       special,
    // result
    output logic [7:0]      merged,
    output logic            accept
);
    import pfp_pkg::*;

    always_comb begin
        merged          = written;
        merged[RNV_BIT] = current[RNV_BIT];
        if (!special) begin
            // high size frozen while window on
            if (!current[HDIS_BIT]) begin
                merged[HS_LSB +: 2] = current[HS_LSB +: 2];
            end
            // low size frozen while window on
            if (!current[LDIS_BIT]) begin
                merged[LS_LSB +: 2] = current[LS_LSB +: 2];
            end
        end
        accept = special || pfp_move_ok(pfp_scenario_of(current), pfp_scenario_of(merged));
    end

endmodule : pfp_scenario

//--- rtl/pfp_top.sv
`timescale 1ns/1ns
module pfp_top #(
    parameter int HADDR_W = 32
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [HADDR_W-1:0]    haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    // mode strap
    input  wire logic                  specialModePin,
    // configuration byte fetch
    output logic                       cfgReq,
    output logic [23:0]                cfgAddr,
    input  wire logic                  cfgValid,
    input  wire logic [7:0]            cfgData,
    input  wire logic                  cfgDoubleFault,
    // program and erase requests
    input  wire logic                  cmdValid,
    input  wire pfp_pkg::pfp_cmd_e     cmdKind,
    input  wire logic [23:0]           cmdAddr,
    output logic                       cmdAccept,
    output logic                       cmdRefused,
    // state view
    output logic [7:0]                 protection,
    output logic                       violation,
    output logic                       loadDone
);
    import pfp_pkg::*;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (HADDR_W < 10) begin : g_bad_width
        $error("HADDR_W must be at least 10");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pfp_state_e  state;
        logic [7:0]  prot;
        logic        viol;
        logic [1:0]  modeSync;
        logic        dpValid;
        logic        dpWrite;
        logic        dpWord;
        logic [1:0]  dpSel;
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
        logic        cmdAccept;
        logic        cmdRefused;
        logic        cfgReq;
        logic [23:0] cfgAddr;
    } pfp_regs_s;

    localparam pfp_regs_s REGS_RESET = '{
        state:     ST_START,
        prot:      PROT_RESET,
        viol:      1'b0,
        modeSync:  2'h0,
        dpValid:   1'b0,
        dpWrite:   1'b0,
        dpWord:    1'b0,
        dpSel:     2'h0,
        hreadyout: 1'b1,
        hrdata:    32'h0000_0000,
        hresp:     1'b0,
        cmdAccept: 1'b0,
        cmdRefused: 1'b0,
        cfgReq:    1'b0,
        cfgAddr:   24'h00_0000
    };

    pfp_regs_s   r;
    pfp_regs_s   next_r;
    logic        special;
    logic        addrPhase;
    logic [1:0]  addrSel;
    logic        wrProt;
    logic        wrStat;
    logic [7:0]  mergedProt;
    logic        mergeOk;
    logic        addrHit;
    logic        cmdHit;
    logic        setViol;
    logic        clearViol;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    assign special   = r.modeSync[1];
    assign addrPhase = hsel && hready && htrans[1];
    assign addrSel   = {haddr == HADDR_W'(STAT_BYTE_ADDR), haddr == HADDR_W'(PROT_BYTE_ADDR)};
    assign wrProt    = r.dpValid && r.dpWrite && r.dpWord && r.dpSel[0] && (r.state == ST_RUN);
    assign wrStat    = r.dpValid && r.dpWrite && r.dpWord && r.dpSel[1];

    pfp_scenario u_scenario (
        .current (r.prot),
        .written (hwdata[7:0]),
        .special (special),
        .merged  (mergedProt),
        .accept  (mergeOk)
    );

    pfp_window_check u_window (
        .prot        (r.prot),
        .addr        (cmdAddr),
        .isProtected (addrHit)
    );

    // block erase needs scenario with no protection
    assign cmdHit    = (cmdKind == CMD_BLOCK_ERASE) ? (pfp_scenario_of(r.prot) != SCEN_NONE) : addrHit;
    assign setViol   = cmdValid && (r.state == ST_RUN) && !r.viol && cmdHit;
    assign clearViol = wrStat && hwdata[VIOL_BIT];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r            = r;
        next_r.modeSync   = {r.modeSync[0], specialModePin};
        next_r.cmdAccept  = 1'b0;
        next_r.cmdRefused = 1'b0;
        next_r.hreadyout  = 1'b1;
        next_r.hresp      = 1'b0;
        next_r.cfgAddr    = CFG_ADDR;
        case (r.state)
            ST_START: begin
                next_r.cfgReq = 1'b1;
                next_r.state  = ST_LOAD;
            end
            ST_LOAD: begin
                if (cfgValid) begin
                    next_r.cfgReq = 1'b0;
                    next_r.state  = ST_RUN;
                    // load from stored byte or fall to full protection
                    next_r.prot   = cfgDoubleFault ? PROT_FAULT : cfgData;
                end
            end
            ST_RUN: begin
                next_r.cfgReq = 1'b0;
            end
            default: begin
                next_r.state  = ST_START;
            end
        endcase
        if (wrProt && mergeOk) begin
            next_r.prot = mergedProt;
        end
        next_r.viol = setViol || (r.viol && !clearViol);
        // refuse on a protected hit or while flag set or loading
        if (cmdValid) begin
            if ((r.state != ST_RUN) || r.viol || cmdHit) begin
                next_r.cmdRefused = 1'b1;
            end else begin
                next_r.cmdAccept  = 1'b1;
            end
        end
        next_r.dpValid = addrPhase;
        next_r.dpWrite = hwrite;
        next_r.dpWord  = (hsize == HSIZE_WORD);
        next_r.dpSel   = addrSel;
        next_r.hrdata  = 32'h0000_0000;
        if (addrPhase && !hwrite) begin
            if (addrSel[0]) begin
                next_r.hrdata = {24'h00_0000, next_r.prot};
            end else if (addrSel[1]) begin
                next_r.hrdata = 32'(next_r.viol) << VIOL_BIT;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hreadyout  = r.hreadyout;
    assign hrdata     = r.hrdata;
    assign hresp      = r.hresp;
    assign cfgReq     = r.cfgReq;
    assign cfgAddr    = r.cfgAddr;
    assign cmdAccept  = r.cmdAccept;
    assign cmdRefused = r.cmdRefused;
    assign protection = r.prot;
    assign violation  = r.viol;
    assign loadDone   = r.state[2];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_prot_read;
        addrPhase && !hwrite && addrSel[0];
    endsequence

    sequence s_viol_clear;
        wrStat && hwdata[VIOL_BIT] && !setViol;
    endsequence

    sequence s_hit_cmd;
        cmdValid && (r.state == ST_RUN) && !r.viol && cmdHit;
    endsequence

    a_prot_read_word: assert property (s_prot_read |=> (hrdata == {24'h00_0000, protection}))
        else $error("protection read returned wrong value");

    a_normal_no_shrink: assert property (!special && $past(loadDone) && $changed(protection)
        |-> pfp_move_ok(pfp_scenario_of($past(protection)), pfp_scenario_of(protection)))
        else $error("normal mode write reduced protection");

    a_special_free_write: assert property (special && wrProt
        |=> protection == {$past(hwdata[7]), $past(protection[6]), $past(hwdata[5:0])})
        else $error("special mode write not taken");

    a_load_byte: assert property ((r.state == ST_LOAD) && cfgValid && !cfgDoubleFault
        |=> (protection == $past(cfgData)) && loadDone)
        else $error("configuration byte not loaded");

    a_fault_full_prot: assert property ((r.state == ST_LOAD) && cfgValid && cfgDoubleFault
        |=> protection == PROT_FAULT)
        else $error("double fault did not protect the array");

    a_hit_sets_viol: assert property (s_hit_cmd |=> violation && cmdRefused && !cmdAccept)
        else $error("protected access not refused");

    a_block_erase_ref: assert property (cmdValid && (cmdKind == CMD_BLOCK_ERASE)
        && (pfp_scenario_of(protection) != SCEN_NONE) |=> cmdRefused)
        else $error("block erase allowed under protection");

    a_open_free_cmd: assert property (cmdValid && loadDone && !violation
        && (pfp_scenario_of(protection) == SCEN_NONE) |=> cmdAccept)
        else $error("unprotected command refused");

    a_high_size_hold: assert property (!special && $past(loadDone) && !$past(protection[HDIS_BIT])
        |-> protection[HS_LSB +: 2] == $past(protection[HS_LSB +: 2]))
        else $error("high size changed while window on");

    a_low_size_hold: assert property (!special && $past(loadDone) && !$past(protection[LDIS_BIT])
        |-> protection[LS_LSB +: 2] == $past(protection[LS_LSB +: 2]))
        else $error("low size changed while window on");

    a_viol_clear_one: assert property (s_viol_clear |=> !violation)
        else $error("violation flag not cleared");

    a_viol_sticky: assert property (violation && !clearViol |=> violation)
        else $error("violation flag dropped without clear");

    a_viol_blocks_cmd: assert property (violation && cmdValid |=> cmdRefused && !cmdAccept)
        else $error("command launched while violation set");

endmodule : pfp_top

//--- rtl/pfp_window_check.sv
`timescale 1ns/1ns
module pfp_window_check (
    // protection setting
    input  wire logic [7:0]  prot,
    // address under test
    input  wire logic [23:0] addr,
    // result
    output logic             isProtected
);
    import pfp_pkg::*;

    logic [23:0] highStart;
    logic [23:0] lowEnd;
    logic        inHigh;
    logic        inLow;

    always_comb begin
        case (prot[HS_LSB +: 2])
            2'h0:    highStart = HIGH_START0;
            2'h1:    highStart = HIGH_START1;
            2'h2:    highStart = HIGH_START2;
            default: highStart = HIGH_START3;
        endcase
        case (prot[LS_LSB +: 2])
            2'h0:    lowEnd = LOW_END0;
            2'h1:    lowEnd = LOW_END1;
            2'h2:    lowEnd = LOW_END2;
            default: lowEnd = LOW_END3;
        endcase
        inHigh = !prot[HDIS_BIT] && (addr >= highStart) && (addr <= HIGH_END);
        inLow  = !prot[LDIS_BIT] && (addr >= LOW_START) && (addr <= lowEnd);
        isProtected = prot[OPEN_BIT] ? (inHigh || inLow) : !(inHigh || inLow);
    end

endmodule : pfp_window_check

//--- shared/pfp_pkg.sv
package pfp_pkg;

    // ----------------------------------------------------------------
    // register map (printed offsets are indices, byte address = 4 x index)
    // ----------------------------------------------------------------
    localparam logic [7:0]  PROT_INDEX      = 8'h08;
    localparam logic [7:0]  STAT_INDEX      = 8'h06;
    localparam logic [9:0]  PROT_BYTE_ADDR  = {PROT_INDEX, 2'b00};
    localparam logic [9:0]  STAT_BYTE_ADDR  = {STAT_INDEX, 2'b00};

    // ----------------------------------------------------------------
    // protection register fields
    // ----------------------------------------------------------------
    localparam int          OPEN_BIT        = 7;
    localparam int          RNV_BIT         = 6;
    localparam int          HDIS_BIT        = 5;
    localparam int          HS_LSB          = 3;
    localparam int          LDIS_BIT        = 2;
    localparam int          LS_LSB          = 0;
    localparam logic [7:0]  PROT_RESET      = 8'h7F;
    localparam logic [7:0]  PROT_FAULT      = 8'h7F;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int          VIOL_BIT        = 4;

    // ----------------------------------------------------------------
    // flash addresses
    // ----------------------------------------------------------------
    localparam logic [23:0] CFG_ADDR        = 24'hFF_FE0C;
    localparam logic [23:0] HIGH_END        = 24'hFF_FFFF;
    localparam logic [23:0] LOW_START       = 24'hFF_8000;
    localparam logic [23:0] HIGH_START0     = 24'hFF_F800;
    localparam logic [23:0] HIGH_START1     = 24'hFF_F000;
    localparam logic [23:0] HIGH_START2     = 24'hFF_E000;
    localparam logic [23:0] HIGH_START3     = 24'hFF_C000;
    localparam logic [23:0] LOW_END0        = 24'hFF_83FF;
    localparam logic [23:0] LOW_END1        = 24'hFF_87FF;
    localparam logic [23:0] LOW_END2        = 24'hFF_8FFF;
    localparam logic [23:0] LOW_END3        = 24'hFF_9FFF;

    // ----------------------------------------------------------------
    // scenarios: index = {open, high disable, low disable}
    // ----------------------------------------------------------------
    localparam logic [2:0]  SCEN_NONE       = 3'h7;
    localparam logic [63:0] SCEN_ALLOWED    = {8'hFF, 8'h5A, 8'h3C, 8'h18, 8'h08, 8'h0C, 8'h0A, 8'h0F};
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    typedef enum logic [1:0] {
        CMD_PROGRAM      = 2'h0,
        CMD_SECTOR_ERASE = 2'h1,
        CMD_BLOCK_ERASE  = 2'h2,
        CMD_OTHER        = 2'h3
    } pfp_cmd_e;

    typedef enum logic [2:0] {
        ST_START = 3'h1,
        ST_LOAD  = 3'h2,
        ST_RUN   = 3'h4
    } pfp_state_e;

    function automatic logic [2:0] pfp_scenario_of(input logic [7:0] prot);
        pfp_scenario_of = {prot[OPEN_BIT], prot[HDIS_BIT], prot[LDIS_BIT]};
    endfunction : pfp_scenario_of

    function automatic logic pfp_move_ok(input logic [2:0] from, input logic [2:0] to);
        pfp_move_ok = SCEN_ALLOWED[{from, to}];
    endfunction : pfp_move_ok

endpackage : pfp_pkg

//--- tb/tb_pfp_top.sv
`timescale 1ns/1ns
module tb_pfp_top;
    import pfp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        ref_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        specialModePin;
    logic        cfgReq;
    logic [23:0] cfgAddr;
    logic        cfgValid;
    logic [7:0]  cfgData;
    logic        cfgDoubleFault;
    logic        cmdValid;
    pfp_cmd_e    cmdKind;
    logic [23:0] cmdAddr;
    logic        cmdAccept;
    logic        cmdRefused;
    logic [7:0]  protection;
    logic        violation;
    logic        loadDone;
    int          errors;
    int          checks_done;
    integer      seed;
    logic [7:0]  expProt;
    logic        expViol;
    logic        special;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic [2:0]  xferSize;
    logic [23:0] edges [19] = '{24'hFF_8000, 24'hFF_83FF, 24'hFF_8400, 24'hFF_87FF, 24'hFF_8800,
        24'hFF_8FFF, 24'hFF_9000, 24'hFF_9FFF, 24'hFF_A000, 24'hFF_BFFF, 24'hFF_C000, 24'hFF_DFFF,
        24'hFF_E000, 24'hFF_EFFF, 24'hFF_F000, 24'hFF_F7FF, 24'hFF_F800, 24'hFF_FFFF, 24'h7F_FFFF};

    assign hready = hreadyout;

    pfp_top dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .specialModePin(specialModePin), .cfgReq(cfgReq),
        .cfgAddr(cfgAddr), .cfgValid(cfgValid), .cfgData(cfgData), .cfgDoubleFault(cfgDoubleFault),
        .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdAccept(cmdAccept),
        .cmdRefused(cmdRefused), .protection(protection), .violation(violation), .loadDone(loadDone));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // expectation model
    // ------------------------------------------------------------
    function automatic logic [2:0] scen(input logic [7:0] p);
        return {p[7], p[5], p[2]};
    endfunction : scen

    function automatic logic move_ok(input logic [2:0] f, input logic [2:0] t);
        logic [7:0] row;
        case (f)
            3'h0: row = 8'h0F;
            3'h1: row = 8'h0A;
            3'h2: row = 8'h0C;
            3'h3: row = 8'h08;
            3'h4: row = 8'h18;
            3'h5: row = 8'h3C;
            3'h6: row = 8'h5A;
            default: row = 8'hFF;
        endcase
        return row[t];
    endfunction : move_ok

    function automatic logic [7:0] next_prot(input logic [7:0] cur, input logic [7:0] wr, input logic sp);
        logic [7:0] cand;
        cand = {wr[7], cur[6], wr[5:0]};
        if (!sp) begin
            if (!cur[5]) cand[4:3] = cur[4:3];
            if (!cur[2]) cand[1:0] = cur[1:0];
            if (!move_ok(scen(cur), scen(cand))) cand = cur;
        end
        return cand;
    endfunction : next_prot

    function automatic logic in_prot(input logic [7:0] p, input logic [23:0] a);
        logic [23:0] hs;
        logic [23:0] le;
        logic        hit;
        hs  = 24'h00_0000 - (24'h00_0800 << p[4:3]);
        le  = 24'hFF_8000 + (24'h00_0400 << p[1:0]) - 24'h00_0001;
        hit = (!p[5] && a >= hs) || (!p[2] && a >= 24'hFF_8000 && a <= le);
        return p[7] ? hit : !hit;
    endfunction : in_prot

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t value got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= xferSize;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        r = hrdata;
        cmp_bit(hresp, 1'b0);
    endtask : ahb_xfer

    task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb_xfer(1'b1, a, d, dummy);
    endtask : ahb_write

    task automatic write_prot(input logic [7:0] w);
        ahb_write(32'(PROT_BYTE_ADDR), {24'h0, w});
        expProt = next_prot(expProt, w, special);
        ahb_xfer(1'b0, 32'(PROT_BYTE_ADDR), 32'h0, rd);
        cmp_val(rd, {24'h0, expProt});
    endtask : write_prot

    task automatic check_stat;
        ahb_xfer(1'b0, 32'(STAT_BYTE_ADDR), 32'h0, rd);
        cmp_val(rd, {27'h0, expViol, 4'h0});
    endtask : check_stat

    task automatic do_reset(input logic [7:0] cfg, input logic df, input logic sp);
        rst            <= 1'b1;
        specialModePin <= sp;
        special         = sp;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        while (cfgReq !== 1'b1) @(posedge ref_clk);
        cmp_val({8'h0, cfgAddr}, {8'h0, CFG_ADDR});
        cfgValid       <= 1'b1;
        cfgData        <= cfg;
        cfgDoubleFault <= df;
        @(posedge ref_clk);
        cfgValid <= 1'b0;
        @(negedge ref_clk);
        expProt = df ? 8'h7F : cfg;
        expViol = 1'b0;
        cmp_bit(loadDone, 1'b1);
        cmp_bit(cfgReq, 1'b0);
        cmp_val({24'h0, protection}, {24'h0, expProt});
    endtask : do_reset

    task automatic do_cmd(input pfp_cmd_e kind, input logic [23:0] a);
        logic hit;
        logic expRef;
        hit    = in_prot(expProt, a);
        expRef = expViol || (kind == CMD_BLOCK_ERASE ? scen(expProt) != 3'h7 : hit);
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdKind  <= kind;
        cmdAddr  <= a;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        @(negedge ref_clk);
        cmp_bit(cmdRefused, expRef);
        cmp_bit(cmdAccept, !expRef);
        if (!expViol && (kind == CMD_BLOCK_ERASE ? scen(expProt) != 3'h7 : hit)) expViol = 1'b1;
        @(negedge ref_clk);
        cmp_bit(violation, expViol);
        if (kind == CMD_BLOCK_ERASE && expViol) begin
            ahb_write(32'(STAT_BYTE_ADDR), 32'h10);
            expViol = 1'b0;
        end
    endtask : do_cmd

    task automatic run_mix(input int n);
        for (int i = 0; i < n; i++) begin
            rnd = $random(seed);
            write_prot(rnd[7:0]);
            repeat (3) begin
                rnd = $random(seed);
                do_cmd(pfp_cmd_e'(rnd[3:2]), rnd[0] ? edges[rnd[9:4] % 19] : {8'hFF, 1'b1, rnd[30:16]});
            end
            rnd = $random(seed);
            ahb_write(32'(STAT_BYTE_ADDR), rnd);
            if (rnd[4]) expViol = 1'b0;
            check_stat;
        end
    endtask : run_mix

    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h5e089e4b;
        errors = 0;
        checks_done = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        xferSize = HSIZE_WORD;
        hwdata = 32'h0;
        specialModePin = 1'b0;
        cfgValid = 1'b0;
        cfgData = 8'h00;
        cfgDoubleFault = 1'b0;
        cmdValid = 1'b0;
        cmdKind = CMD_PROGRAM;
        cmdAddr = 24'h0;
        expProt = 8'h7F;
        expViol = 1'b0;
        special = 1'b0;
        do_reset(8'hFF, 1'b1, 1'b0);
        write_prot(8'hFF);
        do_cmd(CMD_PROGRAM, 24'h00_0000);
        do_cmd(CMD_SECTOR_ERASE, 24'hFF_8000);
        ahb_write(32'(STAT_BYTE_ADDR), 32'h0);
        check_stat;
        ahb_xfer(1'b0, 32'h0000_0040, 32'h0, rd);
        cmp_val(rd, 32'h0);
        do_reset(8'hFF, 1'b0, 1'b1);
        do_cmd(CMD_BLOCK_ERASE, 24'hFF_8000);
        do_cmd(CMD_PROGRAM, CFG_ADDR);
        xferSize = 3'h0;
        ahb_write(32'(PROT_BYTE_ADDR), 32'h0);
        xferSize = HSIZE_WORD;
        ahb_xfer(1'b0, 32'(PROT_BYTE_ADDR), 32'h0, rd);
        cmp_val(rd, {24'h0, expProt});
        write_prot(8'hFB);
        do_cmd(CMD_BLOCK_ERASE, 24'hFF_8000);
        run_mix(40);
        rnd = $random(seed);
        do_reset(rnd[7:0] | 8'h40, 1'b0, 1'b0);
        run_mix(60);
        wrap_up;
    end

    initial begin
        #200000;
        errors++;
        wrap_up;
    end
endmodule : tb_pfp_top
